// File: design/lla_top.sv
`timescale 1ns/1ps
`default_nettype none
module lla_top #(
    parameter logic [15:0] DLY_SHORT_CYC = lla_pkg::DLY_SHORT_CYC,
    parameter logic [15:0] DLY_LONG_CYC  = lla_pkg::DLY_LONG_CYC
) (
    input  wire logic MCLK_I,
    input  wire logic RST_B_I,
    input  wire logic SENSE_ABOVE_I,
    input  wire logic DELAY_SEL_I,
    input  wire logic DUTY_POL_SEL_I,
    output var  logic SENSE_DRV_O,
    output var  logic ALARM_O,
    output var  logic ALARM_LATCHED_O
);
    lla_sense_if sn ();

    lla_pkg::lla_state_t state_reg;
    lla_pkg::lla_state_t state_next;
    logic [15:0]         dly_reg;
    logic [15:0]         dly_limit;
    logic [8:0]          pw_reg;
    logic [8:0]          pw_on;
    logic                alarm_reg;
    logic                latched;

    lla_sense u_sense (
        .clk_i       (MCLK_I),
        .rst_b_i     (RST_B_I),
        .cmp_above_i (SENSE_ABOVE_I),
        .pol_sel_i   (DUTY_POL_SEL_I),
        .sn          (sn)
    );

    assign SENSE_DRV_O = sn.drive;

    assign dly_limit = DELAY_SEL_I ? DLY_LONG_CYC : DLY_SHORT_CYC;
    assign latched   = (state_reg == lla_pkg::LLA_ALARM);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lla_pkg::LLA_IDLE: begin
                if (sn.confirmed) begin
                    state_next = lla_pkg::LLA_DELAY;
                end
            end
            lla_pkg::LLA_DELAY: begin
                if (!sn.confirmed) begin
                    state_next = lla_pkg::LLA_IDLE;
                end else if (dly_reg == dly_limit - 16'h0001) begin
                    state_next = lla_pkg::LLA_ALARM;
                end
            end
            lla_pkg::LLA_ALARM: begin
                // Latched for good: a broken sensor lead must not stop it
                state_next = lla_pkg::LLA_ALARM;
            end
            default: begin
                state_next = lla_pkg::LLA_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg <= lla_pkg::LLA_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Counts from the first confirmed cycle; the delay select is read live
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            dly_reg <= lla_pkg::DLY_RESET;
        end else if (state_next == lla_pkg::LLA_DELAY) begin
            dly_reg <= dly_reg + 16'h0001;
        end else begin
            dly_reg <= lla_pkg::DLY_RESET;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ALARM_LATCHED_O <= 1'b0;
        end else begin
            ALARM_LATCHED_O <= (state_next == lla_pkg::LLA_ALARM);
        end
    end

    assign pw_on = DUTY_POL_SEL_I ? lla_pkg::PW_ON_WIDE : lla_pkg::PW_ON_NARROW;

    // 9-bit counter runs only while latched, wraps at 512
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pw_reg <= lla_pkg::PW_RESET;
        end else if (latched) begin
            pw_reg <= pw_reg + 9'h001;
        end else begin
            pw_reg <= lla_pkg::PW_RESET;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= latched && (pw_reg < pw_on);
        end
    end

    assign ALARM_O = alarm_reg;

    // Helper: independent run length of the confirmed condition
    logic [15:0] run_reg;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            run_reg <= 16'h0000;
        end else if (sn.confirmed && run_reg != 16'hffff) begin
            run_reg <= run_reg + 16'h0001;
        end else if (!sn.confirmed) begin
            run_reg <= 16'h0000;
        end
    end

    sequence s_drive_high;
        $rose(sn.drive) ##16 $fell(sn.drive);
    endsequence

    sequence s_drive_cycle;
        s_drive_high ##16 $rose(sn.drive);
    endsequence

    property p_drive_period;
        @(posedge MCLK_I) disable iff (!RST_B_I)
        $rose(sn.drive) |-> s_drive_cycle;
    endproperty

    a_drive_period:
        assert property (p_drive_period)
        else $error("sensor drive period is not 32 clocks");

    a_drive_half:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            $fell(sn.drive) |-> !sn.drive[*8] ##1 !sn.drive[*8] ##1 $rose(sn.drive))
        else $error("sensor drive low half is not 16 clocks");

    a_sample_high:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            sn.sample_stb |-> sn.drive ##1 !sn.sample_stb)
        else $error("comparator sampled outside the high half");

    sequence s_miss;
        sn.sample_stb && !sn.indicate;
    endsequence

    a_confirm_restart:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            s_miss |=> !sn.confirmed ##96 !sn.confirmed)
        else $error("confirmation did not restart after a miss");

    a_confirm_cause:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            $rose(sn.confirmed) |-> $past(sn.sample_stb && sn.indicate))
        else $error("confirmation rose without an alarm sample");

    a_pol_low:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            !DUTY_POL_SEL_I |-> (sn.indicate == $past(SENSE_ABOVE_I)))
        else $error("select low: above threshold must indicate alarm");

    a_pol_high:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            DUTY_POL_SEL_I |-> (sn.indicate == !$past(SENSE_ABOVE_I)))
        else $error("select high: below threshold must indicate alarm");

    a_delay_length:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            $rose(ALARM_LATCHED_O) |->
                ($past(run_reg) == $past(dly_limit) - 16'h0001))
        else $error("alarm latched after the wrong delay");

    a_delay_abort:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            (!sn.confirmed && !latched) |=> !latched)
        else $error("alarm latched without confirmed condition");

    a_latch_hold:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            ALARM_LATCHED_O |=> ALARM_LATCHED_O)
        else $error("alarm latch released without reset");

    a_reset_clear:
        assert property (@(posedge MCLK_I)
            $rose(RST_B_I) |-> !ALARM_LATCHED_O && !ALARM_O && dly_reg == 16'h0000)
        else $error("reset did not clear alarm state");

    // Helper: clocks since the last alarm rise; too long for a plain delay
    logic       alarm_q_reg;
    logic       alarm_seen_reg;
    logic       alarm_rise;
    logic [9:0] alarm_gap_reg;

    assign alarm_rise = ALARM_O && !alarm_q_reg;

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            alarm_q_reg    <= 1'b0;
            alarm_seen_reg <= 1'b0;
            alarm_gap_reg  <= 10'h000;
        end else begin
            alarm_q_reg <= ALARM_O;
            if (alarm_rise) begin
                alarm_seen_reg <= 1'b1;
                alarm_gap_reg  <= 10'h001;
            end else if (alarm_gap_reg != 10'h3ff) begin
                alarm_gap_reg <= alarm_gap_reg + 10'h001;
            end
        end
    end

    a_alarm_period:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            alarm_seen_reg |-> (alarm_rise == (alarm_gap_reg == 10'h200)))
        else $error("alarm wave period is not 512 clocks");

    a_on_wide:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            ($rose(ALARM_O) && DUTY_POL_SEL_I) |-> ##256 $fell(ALARM_O))
        else $error("wide on time is not 256 clocks");

    a_on_narrow:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            ($rose(ALARM_O) && !DUTY_POL_SEL_I) |-> ALARM_O[*8] ##1 !ALARM_O)
        else $error("narrow on time is not 8 clocks");

    a_alarm_idle:
        assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
            !latched |=> !ALARM_O)
        else $error("alarm output active while latch clear");
endmodule // lla_top
`default_nettype wire

// File: design/lla_pkg.sv
// Notes on behaviour
// - Sensor drive period is 32 clocks
// - Sensor drive high and low halves equal
// - Comparator only sampled in high half
// - Four consecutive alarm samples confirm; miss restarts
// - Select low: above threshold means alarm
// - Select high: below threshold means alarm
// - Delay 16384 or 32768 clocks before alarm
// - Condition lost during delay aborts it
// - Alarm latch holds until reset
// - Reset clears latch, confirm and delay counters
// - Alarm wave period is 512 clocks
// - On time 256 (select high) or 8
`default_nettype none
package lla_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

    // Sensor drive divider
    localparam int unsigned DRV_DIV       = 32;
    localparam int unsigned DRV_HALF      = DRV_DIV / 2;
    localparam logic [4:0]  PH_RESET      = 5'h00;
    localparam logic [4:0]  PH_SAMPLE     = 5'h0f;

    // Confirmation
    localparam logic [2:0]  CONF_RESET    = 3'h0;
    localparam logic [2:0]  CONF_NEEDED   = 3'h4;

    // Delay, in oscillator cycles
    localparam logic [15:0] DLY_SHORT_CYC = 16'h4000;
    localparam logic [15:0] DLY_LONG_CYC  = 16'h8000;
    localparam logic [15:0] DLY_RESET     = 16'h0000;

    // Alarm output wave
    localparam logic [8:0]  PW_RESET      = 9'h000;
    localparam logic [8:0]  PW_PERIOD     = 9'h1ff;
    localparam logic [8:0]  PW_ON_WIDE    = 9'h100;
    localparam logic [8:0]  PW_ON_NARROW  = 9'h008;

    typedef enum logic [2:0] {
        LLA_IDLE  = 3'b001,
        LLA_DELAY = 3'b010,
        LLA_ALARM = 3'b100
    } lla_state_t;
endpackage
`default_nettype wire

// File: design/lla_sense_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lla_sense_if;
    logic drive;
    logic sample_stb;
    logic indicate;
    logic confirmed;

    modport sense (
        output drive,
        output sample_stb,
        output indicate,
        output confirmed
    );
    modport ctrl (
        input drive,
        input sample_stb,
        input indicate,
        input confirmed
    );
endinterface
`default_nettype wire

// File: design/lla_sense.sv
`timescale 1ns/1ps
`default_nettype none
module lla_sense (
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    input  wire logic   cmp_above_i,
    input  wire logic   pol_sel_i,
    lla_sense_if.sense  sn
);
    logic [4:0] ph_reg;
    logic [4:0] ph_next;
    logic       drive_reg;
    logic       cmp_reg;
    logic [2:0] conf_reg;
    logic [2:0] conf_next;
    logic       ind;

    assign ph_next = ph_reg + 5'h01;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_reg    <= lla_pkg::PH_RESET;
            drive_reg <= 1'b1;
        end else begin
            ph_reg    <= ph_next;
            drive_reg <= ~ph_next[4];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_reg <= 1'b0;
        end else begin
            cmp_reg <= cmp_above_i;
        end
    end

    // Polarity select flips which side of the threshold is the alarm
    assign ind = pol_sel_i ? ~cmp_reg : cmp_reg;

    // Sample on the last clock of the high half only
    assign sn.sample_stb = drive_reg && (ph_reg == lla_pkg::PH_SAMPLE);

    always_comb begin
        conf_next = conf_reg;
        if (sn.sample_stb) begin
            if (!ind) begin
                conf_next = lla_pkg::CONF_RESET;
            end else if (conf_reg != lla_pkg::CONF_NEEDED) begin
                conf_next = conf_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conf_reg <= lla_pkg::CONF_RESET;
        end else begin
            conf_reg <= conf_next;
        end
    end

    assign sn.drive     = drive_reg;
    assign sn.indicate  = ind;
    assign sn.confirmed = (conf_reg == lla_pkg::CONF_NEEDED);
endmodule // lla_sense
`default_nettype wire

// File: tb/lla_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module lla_sensor_model (
    input  wire logic drive_i,
    input  wire logic pol_sel_i,
    input  wire logic cond_i,
    output var  logic above_o
);
    // Low half shows the opposite level, so sampling there would be caught
    always_comb begin
        if (drive_i) begin
            above_o = cond_i ^ pol_sel_i;
        end else begin
            above_o = ~(cond_i ^ pol_sel_i);
        end
    end
endmodule // lla_sensor_model
`default_nettype wire

// File: tb/test_liquid_level_alarm_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_liquid_level_alarm_sequencer;
    localparam logic [15:0] SHORT_CYC = 16'h0040;
    localparam logic [15:0] LONG_CYC  = 16'h0080;
    logic mclk         = 1'b0;
    logic rst_b        = 1'b0;
    logic cond         = 1'b0;
    logic delay_sel    = 1'b0;
    logic duty_pol_sel = 1'b0;
    wire logic sense_above;
    wire logic sense_drv;
    wire logic alarm;
    wire logic alarm_latched;
    int miscompares  = 0;
    int total_checks = 0;
    int hi;
    int per;
    int cnt;

    always #25 mclk = ~mclk;

    lla_top #(.DLY_SHORT_CYC(SHORT_CYC), .DLY_LONG_CYC(LONG_CYC)) u_lla_top (
        .MCLK_I          (mclk),
        .RST_B_I         (rst_b),
        .SENSE_ABOVE_I   (sense_above),
        .DELAY_SEL_I     (delay_sel),
        .DUTY_POL_SEL_I  (duty_pol_sel),
        .SENSE_DRV_O     (sense_drv),
        .ALARM_O         (alarm),
        .ALARM_LATCHED_O (alarm_latched)
    );

    lla_sensor_model u_lla_sensor_model (
        .drive_i   (sense_drv),
        .pol_sel_i (duty_pol_sel),
        .cond_i    (cond),
        .above_o   (sense_above)
    );

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_bit(input logic exp, input logic act);
        total_checks++;
        if (act !== exp) begin
            miscompares++;
            $display("Error at %0t: expected %h got %h", $time, exp, act);
        end
    endtask

    task automatic check_count(input int lo, input int lim, input int act);
        total_checks++;
        if (act < lo || act > lim) begin
            miscompares++;
            $display("Error at %0t: expected %h..%h got %h", $time, lo, lim, act);
        end
    endtask

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    function automatic logic pick(input logic [1:0] sel);
        return (sel == 2'h2) ? alarm_latched : ((sel == 2'h1) ? alarm : sense_drv);
    endfunction

    // Counts clocks until the chosen output reaches lvl; a hang ends the run
    task automatic wait_level(input logic [1:0] sel, input logic lvl, input int lim,
                              output int n);
        n = 0;
        while (pick(sel) !== lvl) begin
            if (n >= lim) begin
                miscompares++;
                $display("Error at %0t: expected %h got %h", $time, lvl, pick(sel));
                final_report();
            end
            tick();
            n++;
        end
    endtask

    task automatic measure(input logic [1:0] sel, output int h, output int p);
        int n;
        wait_level(sel, 1'b0, 600, n);
        wait_level(sel, 1'b1, 600, n);
        wait_level(sel, 1'b0, 600, h);
        wait_level(sel, 1'b1, 600, n);
        p = h + n;
    endtask

    // Condition is changed in the low half so a whole high half carries it
    task automatic samples(input int n, input logic c);
        int t;
        for (int i = 0; i < n; i++) begin
            wait_level(2'h0, 1'b0, 40, t);
            cond = c;
            wait_level(2'h0, 1'b1, 40, t);
            wait_level(2'h0, 1'b0, 40, t);
        end
    endtask

    task automatic sc_reset_wave;
        rst_b = 1'b0;
        repeat (20) tick();
        check_bit(1'b1, sense_drv);
        check_bit(1'b0, alarm_latched);
        check_bit(1'b0, alarm);
        rst_b = 1'b1;
        measure(2'h0, hi, per);
        check_count(16, 16, hi);
        check_count(32, 32, per);
    endtask

    task automatic sc_miss_restart;
        samples(3, 1'b1);
        samples(1, 1'b0);
        samples(3, 1'b1);
        samples(1, 1'b0);
        repeat (SHORT_CYC + 16) tick();
        check_bit(1'b0, alarm_latched);
        check_bit(1'b0, alarm);
    endtask

    task automatic sc_short_delay;
        samples(4, 1'b1);
        wait_level(2'h2, 1'b1, 400, cnt);
        check_count(SHORT_CYC, SHORT_CYC, cnt);
        measure(2'h1, hi, per);
        check_count(8, 8, hi);
        check_count(512, 512, per);
        samples(5, 1'b0);
        check_bit(1'b1, alarm_latched);
        rst_b = 1'b0;
        tick();
        check_bit(1'b0, alarm_latched);
        check_bit(1'b0, alarm);
        repeat (19) tick();
        rst_b = 1'b1;
    endtask

    task automatic sc_abort_long;
        duty_pol_sel = 1'b1;
        delay_sel    = 1'b1;
        samples(4, 1'b1);
        samples(1, 1'b0);
        repeat (LONG_CYC + 16) tick();
        check_bit(1'b0, alarm_latched);
        samples(4, 1'b1);
        wait_level(2'h2, 1'b1, 400, cnt);
        check_count(LONG_CYC, LONG_CYC, cnt);
        measure(2'h1, hi, per);
        check_count(256, 256, hi);
        check_count(512, 512, per);
    endtask

    initial begin
        sc_reset_wave();
        sc_miss_restart();
        sc_short_delay();
        sc_abort_long();
        final_report();
    end
endmodule // test_liquid_level_alarm_sequencer
`default_nettype wire
